// [rtl/pager_consts.svh]
// Offsets, field positions, codes and reset values of the report packet framer.
// Included by the framer; holds definitions only.
`ifndef PAGER_CONSTS_SVH
`define PAGER_CONSTS_SVH
`define OFS_CTRL        8'h00
`define OFS_WORD_PKT    8'h04
`define OFS_ROAM_PKT    8'h08
`define OFS_STAT        8'h0C
`define CTRL_RESET      6'h00
`define CTRL_IGN_RESYNC 0
`define CTRL_MISSED_FR  1
`define CTRL_NET_BIT    2
`define CTRL_AUTO_NOISE 3
`define CTRL_CONT_NOISE 4
`define CTRL_MAN_COLL   5
`define VTYPE_SHORT_INS 3'h1
`define INSTR_TA_MSN    3'h2
`define ROAM_HEADER     8'h60
`define VEC_POS_MIN     7'h02
`define MSG_POS_MIN     7'h03
`define WORD_POS_MAX    7'h57
`define MAX_GOOD_ERRS   3'h2
`define NOISE_NOT_FOUND 2'h3
`define NOISE_NONE      2'h0
`endif

// [rtl/pager_pkg.sv]
// Types shared by the report packet framer.
// Relies on nothing outside itself.
package pager_pkg;
  typedef logic [31:0] packet_t;
  typedef enum logic [1:0] {
    NOISE_NO_INFO   = 2'h0,
    NOISE_ABANDONED = 2'h1,
    NOISE_FOUND     = 2'h2,
    NOISE_MISSING   = 2'h3
  } noise_e;
endpackage

// [rtl/pager_packet_framer.sv]
// Report packet framer: vector, message and roaming status packets, read over APB.
// Word reports come from decoder logic on MCLK; frame events are levels
// timed by the link clock SYM_CLK and are synchronised here.
`timescale 1ns/100ps
`include "pager_consts.svh"

module pager_packet_framer #(
  parameter int ADDR_W = 8
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        WORD_VALID,
  input  wire logic        WORD_IS_VECTOR,
  input  wire logic        WORD_LONG_ADDR,
  input  wire logic [6:0]  WORD_POS,
  input  wire logic [1:0]  WORD_PHASE,
  input  wire logic [2:0]  WORD_ERRS,
  input  wire logic        WORD_CHK_FAIL,
  input  wire logic [20:0] WORD_INFO,
  input  wire logic        SYM_CLK,
  input  wire logic        EV_FRAME_START,
  input  wire logic        EV_RESYNC,
  input  wire logic        EV_NO_SYNC_ONE,
  input  wire logic        EV_NO_SYNC_TWO,
  input  wire logic        EV_FI_BAD,
  input  wire logic        EV_FI_GOOD,
  input  wire logic        EV_NET_BIT,
  input  wire logic        EV_BI_BAD,
  input  wire logic        EV_BI_GOOD,
  input  wire logic        EV_ADDR_BAD,
  input  wire logic        EV_COLLAPSE,
  input  wire logic [2:0]  EV_COLLAPSE_VAL,
  input  wire logic        EV_NOISE_DONE,
  input  wire logic [1:0]  EV_NOISE_RESULT,
  input  wire logic        HOST_NOISE_REQUEST,
  output logic             HOST_ATTN
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 4 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link-side synchronisers and sampling on the link clock's rising edge.

  localparam int EV_W = 18;

  logic [EV_W-1:0] ev_raw;
  logic [EV_W-1:0] ev_meta;
  logic [EV_W-1:0] ev_sync;
  logic [1:0]      lclk_meta;
  logic [1:0]      lclk_sync;
  logic            lclk_rise;

  assign ev_raw = {EV_FRAME_START, EV_RESYNC, EV_NO_SYNC_ONE, EV_NO_SYNC_TWO,
                   EV_FI_BAD, EV_FI_GOOD, EV_NET_BIT, EV_BI_BAD, EV_BI_GOOD,
                   EV_ADDR_BAD, EV_COLLAPSE, EV_COLLAPSE_VAL, EV_NOISE_DONE,
                   EV_NOISE_RESULT, HOST_NOISE_REQUEST};

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ev_meta   <= '0;
      ev_sync   <= '0;
      lclk_meta <= 2'h0;
      lclk_sync <= 2'h0;
    end else if (CE) begin
      ev_meta   <= ev_raw;
      ev_sync   <= ev_meta;
      lclk_meta <= {lclk_meta[0], SYM_CLK};
      lclk_sync <= {lclk_sync[0], lclk_meta[1]};
    end
  end

  // Events are sampled once per link bit, a cycle after the clock edge is
  // seen, so the event levels have had a cycle more settling than the clock.
  assign lclk_rise = CE && lclk_sync[0] && !lclk_sync[1];

  logic       e_frame, e_resync, e_ns1, e_ns2, e_fi_bad, e_fi_good, e_net;
  logic       e_bi_bad, e_bi_good, e_addr_bad, e_coll, e_noise, e_host_req;
  logic [2:0] e_coll_val;
  logic [1:0] e_noise_res;

  assign e_frame     = lclk_rise && ev_sync[17];
  assign e_resync    = lclk_rise && ev_sync[16];
  assign e_ns1       = lclk_rise && ev_sync[15];
  assign e_ns2       = lclk_rise && ev_sync[14];
  assign e_fi_bad    = lclk_rise && ev_sync[13];
  assign e_fi_good   = lclk_rise && ev_sync[12];
  assign e_net       = ev_sync[11];
  assign e_bi_bad    = lclk_rise && ev_sync[10];
  assign e_bi_good   = lclk_rise && ev_sync[9];
  assign e_addr_bad  = lclk_rise && ev_sync[8];
  assign e_coll      = lclk_rise && ev_sync[7];
  assign e_coll_val  = ev_sync[6:4];
  assign e_noise     = lclk_rise && ev_sync[3];
  assign e_noise_res = ev_sync[2:1];
  assign e_host_req  = ev_sync[0];

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave decode.

  logic [5:0]  ctrl;
  logic        setup_ph;
  logic        access_ph;
  logic [7:0]  ofs;
  logic        hit_ctrl, hit_word, hit_roam, hit_stat, hit_any;
  logic        rd_word, rd_roam, rd_stat, wr_ctrl;
  logic [31:0] read_mux;

  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign ofs       = 8'(PADDR);
  assign setup_ph  = PSEL && !PENABLE;
  assign access_ph = CE && PSEL && PENABLE;
  assign hit_ctrl  = is_ofs(ofs, `OFS_CTRL);
  assign hit_word  = is_ofs(ofs, `OFS_WORD_PKT);
  assign hit_roam  = is_ofs(ofs, `OFS_ROAM_PKT);
  assign hit_stat  = is_ofs(ofs, `OFS_STAT);
  assign hit_any   = (hit_ctrl || hit_word || hit_roam || hit_stat)
                     && (ADDR_W <= 8 || PADDR == ADDR_W'(ofs));
  assign wr_ctrl   = access_ph && PWRITE && hit_ctrl && hit_any;
  assign rd_word   = access_ph && !PWRITE && hit_word && hit_any;
  assign rd_roam   = access_ph && !PWRITE && hit_roam && hit_any;
  assign rd_stat   = access_ph && !PWRITE && hit_stat && hit_any;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !hit_any;

  ////////////////////////////////////////////////////////////////////////////////
  // Word packets: short instruction vectors and message words.

  pager_pkg::packet_t word_pkt;
  logic        word_valid;
  logic        word_overrun;
  logic        msg_allow;
  logic        vec_err, msg_err, vec_in_range, msg_in_range;
  logic        vec_load, msg_load;
  logic [10:0] vec_data;
  logic [2:0]  vec_instr;
  pager_pkg::packet_t vec_pkt, msg_pkt;

  assign vec_err      = (WORD_ERRS > `MAX_GOOD_ERRS) || WORD_CHK_FAIL;
  assign msg_err      = WORD_ERRS > `MAX_GOOD_ERRS;
  assign vec_in_range = WORD_POS >= `VEC_POS_MIN && WORD_POS <= `WORD_POS_MAX;
  assign msg_in_range = WORD_POS >= `MSG_POS_MIN && WORD_POS <= `WORD_POS_MAX;
  assign vec_load     = CE && WORD_VALID && WORD_IS_VECTOR && vec_in_range;
  assign msg_load     = CE && WORD_VALID && !WORD_IS_VECTOR && msg_allow && msg_in_range;

  // The instruction field and all eleven data bits keep their received order,
  // so the 000, 001, 010 and reserved layouts need no remapping.
  // data passthrough
  assign vec_data  = WORD_INFO[13:3];
  assign vec_instr = WORD_INFO[2:0];

  assign vec_pkt = {1'b0, WORD_POS, vec_err, WORD_PHASE, 2'b00, `VTYPE_SHORT_INS,
                    2'b00, vec_data, vec_instr};
  assign msg_pkt = {1'b0, WORD_POS, msg_err, WORD_PHASE, WORD_INFO};

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      word_pkt     <= '0;
      word_valid   <= 1'b0;
      word_overrun <= 1'b0;
      msg_allow    <= 1'b0;
    end else if (CE) begin
      if (vec_load) begin
        word_pkt <= vec_pkt;
      end else if (msg_load) begin
        word_pkt <= msg_pkt;
      end
      word_valid   <= vec_load || msg_load || (word_valid && !rd_word);
      word_overrun <= ((vec_load || msg_load) && word_valid && !rd_word)
                      || (word_overrun && !rd_stat);
      if (WORD_VALID) begin
        msg_allow <= WORD_IS_VECTOR && vec_in_range && WORD_LONG_ADDR && !vec_err;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Roaming status flags 7 to 1, set by frame events and cleared by reading them; bit 0 keeps the last network bit.

  logic [7:0] roam_flags;
  logic [1:0] noise_res;
  logic       coll_upd;
  logic [2:0] coll_val;
  logic       bi_seen, addr_seen, coll_seen, bi_good_seen, sync1_missed;
  logic [7:1] flag_set;
  logic [7:1] flag_clr;
  logic       noise_take;
  logic       coll_take;
  logic       net_take;
  logic [31:0] roam_pkt;
  logic [31:0] roam_snap;
  logic       roam_any;

  assign net_take = ctrl[`CTRL_NET_BIT] && e_fi_good && (!sync1_missed || e_frame) && !e_ns1;

  assign flag_set[7] = e_resync && ctrl[`CTRL_IGN_RESYNC];
  assign flag_set[6] = e_ns1 && ctrl[`CTRL_MISSED_FR];
  assign flag_set[4] = e_ns2 && ctrl[`CTRL_MISSED_FR];
  assign flag_set[5] = e_fi_bad && ctrl[`CTRL_MISSED_FR];
  // A frame start in the same sample opens a fresh frame at once.
  // once per frame
  assign flag_set[3] = e_bi_bad && ctrl[`CTRL_MISSED_FR] && (!bi_seen || e_frame);
  assign flag_set[2] = e_addr_bad && ctrl[`CTRL_MISSED_FR] && (!addr_seen || e_frame);
  assign flag_set[1] = net_take;

  assign noise_take = e_noise && e_noise_res != `NOISE_NONE
                      && (e_host_req || ctrl[`CTRL_AUTO_NOISE])
                      && (!ctrl[`CTRL_CONT_NOISE] || e_noise_res == `NOISE_NOT_FOUND);
  assign coll_take  = e_coll && ctrl[`CTRL_MAN_COLL] && (!coll_seen || e_frame)
                      && ((bi_good_seen && !e_frame) || e_bi_good);

  // Only bits that the host actually saw are cleared, so an event landing
  // between the setup and access phases survives the read.
  assign flag_clr = rd_roam ? roam_snap[23:17] : 7'h00;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      roam_flags <= 8'h00;
      noise_res  <= `NOISE_NONE;
      coll_upd   <= 1'b0;
      coll_val   <= 3'h0;
    end else if (CE) begin
      roam_flags[7:1] <= flag_set[7:1] | (roam_flags[7:1] & ~flag_clr[7:1]);
      if (net_take) begin
        roam_flags[0] <= e_net;
      end
      if (noise_take) begin
        noise_res <= e_noise_res;
      end else if (rd_roam && roam_snap[9:8] == noise_res) begin
        noise_res <= `NOISE_NONE;
      end
      if (coll_take) begin
        coll_upd <= 1'b1;
        coll_val <= e_coll_val;
      end else if (rd_roam && roam_snap[3]) begin
        coll_upd <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      bi_seen      <= 1'b0;
      addr_seen    <= 1'b0;
      coll_seen    <= 1'b0;
      bi_good_seen <= 1'b0;
      sync1_missed <= 1'b0;
    end else if (CE) begin
      bi_seen      <= (bi_seen && !e_frame) || flag_set[3];
      addr_seen    <= (addr_seen && !e_frame) || flag_set[2];
      coll_seen    <= (coll_seen && !e_frame) || coll_take;
      bi_good_seen <= (bi_good_seen && !e_frame) || e_bi_good;
      sync1_missed <= (sync1_missed && !e_frame) || e_ns1;
    end
  end

  assign roam_pkt = {`ROAM_HEADER, roam_flags, 6'h00, noise_res, 4'h0, coll_upd, coll_val};
  assign roam_any = |roam_flags[7:1] || noise_res != `NOISE_NONE || coll_upd;
  assign HOST_ATTN = roam_any || word_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register, written in the access phase, and read data, captured in the setup phase.

  assign read_mux = !hit_any ? 32'h0000_0000 :
                    hit_ctrl ? {26'h0, ctrl} :
                    hit_word ? (word_valid ? word_pkt : 32'h0000_0000) :
                    hit_roam ? roam_pkt :
                    {29'h0, word_overrun, roam_any, word_valid};

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ctrl      <= `CTRL_RESET;
      PRDATA    <= 32'h0000_0000;
      roam_snap <= 32'h0000_0000;
    end else if (CE) begin
      if (wr_ctrl) begin
        ctrl <= PWDATA[5:0];
      end
      if (setup_ph && !PWRITE) begin
        PRDATA    <= read_mux;
        roam_snap <= roam_pkt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence good_long_vector;
    vec_load && WORD_LONG_ADDR && !vec_err;
  endsequence

  sequence next_message_word;
    CE && WORD_VALID && !WORD_IS_VECTOR && msg_in_range;
  endsequence

  a_vec_type_code: assert property (vec_load |=> word_pkt[18:16] == 3'h1)
    else $error("vector type field is not 001");

  a_vec_top_byte: assert property (vec_load |=> word_pkt[31:24] == {1'b0, $past(WORD_POS)})
    else $error("vector top byte wrong");

  a_vec_pos_range: assert property (word_valid && !word_pkt[31] && word_pkt[18:16] == 3'h1
                                   |-> word_pkt[30:24] >= 7'h02)
    else $error("vector position below range");

  a_vec_error_bit: assert property (vec_load && WORD_ERRS > 3'h2 |=> word_pkt[23])
    else $error("vector error bit not set");

  a_phase_copy: assert property ((vec_load || msg_load) |=> word_pkt[22:21] == $past(WORD_PHASE))
    else $error("phase field wrong");

  a_msg_follows: assert property (good_long_vector ##1 next_message_word
                                  |=> word_valid && word_pkt[20:0] == $past(WORD_INFO))
    else $error("message word after good long vector not framed");

  a_msg_gated: assert property (!msg_allow && CE && WORD_VALID && !WORD_IS_VECTOR && !vec_load
                                |=> word_pkt == $past(word_pkt))
    else $error("message framed without a good vector");

  a_msg_ident: assert property (msg_load |=> word_pkt[30:24] == $past(WORD_POS)
                                && word_pkt[31] == 1'b0)
    else $error("message identifier wrong");

  a_roam_header: assert property (roam_pkt[31:24] == 8'h60 && roam_pkt[15:10] == 6'h00)
    else $error("roaming header wrong");

  a_attn_roam: assert property (roam_any |-> HOST_ATTN)
    else $error("host not prompted for roaming status");

  a_resync_clear: assert property (rd_roam && roam_snap[23] && !flag_set[7]
                                   |=> !roam_flags[7])
    else $error("resync flag not cleared by read");

  a_missed_once: assert property (bi_seen && !e_frame |-> !flag_set[3])
    else $error("missed block info set twice in a frame");

  a_noise_cont: assert property (noise_take && ctrl[4] |-> e_noise_res == 2'h3)
    else $error("continuous detect reported other than not detected");

  a_collapse_take: assert property (coll_take |=> coll_upd && coll_val == $past(e_coll_val))
    else $error("collapse update not captured");

endmodule

// [sim/link_event_model.sv]
// Link-side event source standing in for the radio front end of the decoder.
// Assumes the framer samples its event levels at each rise of the symbol clock.
`timescale 1ns/100ps
module link_event_model (
  output logic        sym_clk,
  output logic [12:0] ev,
  output logic [2:0]  coll_val,
  output logic [1:0]  noise_res
);
  initial begin
    sym_clk   = 1'b0;
    ev        = 13'h0000;
    coll_val  = 3'h0;
    noise_res = 2'h0;
  end

  ////////////////////////////////////////
  // One link period of 320 ns: levels settle while the clock is low and stay
  // across the rise. The clock then stands low, so no stray sample is taken.
  // The value fields are inverted once released, so stale data cannot pass.
  // Levels move a few ns after the caller's clock edge, never on it.
  task automatic send(input logic [12:0] m, input logic [2:0] cv, input logic [1:0] nr);
    #7;
    ev        = m;
    coll_val  = cv;
    noise_res = nr;
    #160;
    sym_clk = 1'b1;
    #160;
    sym_clk   = 1'b0;
    ev        = 13'h0000;
    coll_val  = ~cv;
    noise_res = ~nr;
  endtask
endmodule

// [sim/pager_packet_framer_tb.sv]
// Self-checking bench of the report packet framer, registers read over APB.
// Assumes the link event model; events: bit 0 frame start up to bit 12 host request.
`timescale 1ns/100ps
`include "pager_consts.svh"
module pager_packet_framer_tb;
  logic        mclk, nrst, ce, psel, penable, pwrite, pready, pslverr, attn;
  logic        wv, wvec, wlong, wchk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        rerr;
  logic [6:0]  wpos;
  logic [1:0]  wph, nr;
  logic [2:0]  werr, cv;
  logic [20:0] winfo;
  logic        sym;
  logic [12:0] ev;
  int          n_fail, tests_run;

  pager_packet_framer #(.ADDR_W(8)) u_pager_packet_framer (
    .MCLK(mclk), .NRST(nrst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WORD_VALID(wv), .WORD_IS_VECTOR(wvec),
    .WORD_LONG_ADDR(wlong), .WORD_POS(wpos), .WORD_PHASE(wph), .WORD_ERRS(werr),
    .WORD_CHK_FAIL(wchk), .WORD_INFO(winfo), .SYM_CLK(sym), .EV_FRAME_START(ev[0]),
    .EV_RESYNC(ev[1]), .EV_NO_SYNC_ONE(ev[2]), .EV_NO_SYNC_TWO(ev[3]),
    .EV_FI_BAD(ev[4]), .EV_FI_GOOD(ev[5]), .EV_NET_BIT(ev[6]), .EV_BI_BAD(ev[7]),
    .EV_BI_GOOD(ev[8]), .EV_ADDR_BAD(ev[9]), .EV_COLLAPSE(ev[10]),
    .EV_COLLAPSE_VAL(cv), .EV_NOISE_DONE(ev[11]), .EV_NOISE_RESULT(nr),
    .HOST_NOISE_REQUEST(ev[12]), .HOST_ATTN(attn));

  link_event_model u_link_event_model (
    .sym_clk(sym), .ev(ev), .coll_val(cv), .noise_res(nr));

  always #20 mclk = ~mclk;

  ////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Setup then access; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) n_fail++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, x);
  endtask

  task automatic word(input logic v, l, input logic [6:0] p, input logic [1:0] ph,
                      input logic [2:0] e, input logic k, input logic [20:0] inf);
    wv    <= 1'b1;
    wvec  <= v;
    wlong <= l;
    wpos  <= p;
    wph   <= ph;
    werr  <= e;
    wchk  <= k;
    winfo <= inf;
    @(posedge mclk);
    wv <= 1'b0;
    @(posedge mclk);
  endtask

  // The sync chain needs a few cycles after the link rise before flags land.
  task automatic evs(input logic [12:0] m, input logic [2:0] c, input logic [1:0] r);
    u_link_event_model.send(m, c, r);
    repeat (6) @(posedge mclk);
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    chk("attn reset", 32'(attn), 32'h0);
    rchk(`OFS_CTRL, 32'h0, "ctrl reset");
    rchk(`OFS_ROAM_PKT, 32'h6000_0000, "roam reset");
    rchk(`OFS_WORD_PKT, 32'h0, "word reset");
    apb(1'b1, `OFS_CTRL, 32'h3F);
    rchk(`OFS_CTRL, 32'h3F, "ctrl rw");
    apb(1'b1, `OFS_WORD_PKT, 32'hFFFF_FFFF);
    rchk(`OFS_WORD_PKT, 32'h0, "word read only");
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    chk("unmapped data", rdat, 32'h0);
    $display("test reset done");
  endtask

  // every instruction code, both position bounds.
  task automatic t_vec;
    logic [6:0]  p;
    logic [10:0] d;
    logic        k;
    logic        xe;
    for (int i = 0; i < 8; i++) begin
      p  = i[0] ? `WORD_POS_MAX : `VEC_POS_MIN;
      d  = 11'h5A5 ^ 11'(i);
      k  = (i == 5);
      xe = (3'(i & 3) > `MAX_GOOD_ERRS) || k;
      word(1'b1, 1'b0, p, 2'(i), 3'(i & 3), k, {7'h00, d, 3'(i)});
      rchk(`OFS_WORD_PKT, {1'b0, p, xe, 2'(i), 2'h0, `VTYPE_SHORT_INS,
           2'h0, d, 3'(i)}, "vector");
    end
    word(1'b1, 1'b0, 7'h01, 2'h0, 3'h0, 1'b0, 21'h0);
    word(1'b1, 1'b0, 7'h58, 2'h0, 3'h0, 1'b0, 21'h0);
    rchk(`OFS_STAT, 32'h0, "range drop");
    $display("test vector done");
  endtask

  task automatic pair(input logic [2:0] ve, input logic lg, input logic [6:0] mp,
                      input logic [2:0] me, input logic ok);
    word(1'b1, lg, `VEC_POS_MIN, 2'h1, ve, 1'b0, {7'h00, 11'h123, `INSTR_TA_MSN});
    apb(1'b0, `OFS_WORD_PKT, 32'h0);
    word(1'b0, 1'b0, mp, 2'h3, me, 1'b0, 21'h1ABCDE);
    rchk(`OFS_WORD_PKT, ok ? {1'b0, mp, me > `MAX_GOOD_ERRS, 2'h3, 21'h1ABCDE}
         : 32'h0, "message");
  endtask

  task automatic t_msg;
    pair(3'h0, 1'b1, `MSG_POS_MIN, 3'h0, 1'b1);
    pair(3'h0, 1'b1, `WORD_POS_MAX, 3'h3, 1'b1);
    pair(3'h3, 1'b1, 7'h0A, 3'h0, 1'b0);
    pair(3'h0, 1'b0, 7'h0A, 3'h0, 1'b0);
    pair(3'h0, 1'b1, 7'h02, 3'h0, 1'b0);
    // Message word in the cycle right after its vector; it overwrites the vector.
    wv    <= 1'b1;
    wvec  <= 1'b1;
    wlong <= 1'b1;
    wpos  <= 7'h05;
    wph   <= 2'h2;
    werr  <= 3'h0;
    wchk  <= 1'b0;
    winfo <= {7'h00, 11'h000, `INSTR_TA_MSN};
    @(posedge mclk);
    word(1'b0, 1'b0, 7'h06, 2'h2, 3'h1, 1'b0, 21'h0F0F0);
    rchk(`OFS_WORD_PKT, {1'b0, 7'h06, 1'b0, 2'h2, 21'h0F0F0}, "back to back");
    rchk(`OFS_STAT, 32'h4, "overrun set");
    rchk(`OFS_STAT, 32'h0, "overrun cleared");
    $display("test message done");
  endtask

  // With the clock enable low a presented word must not be taken.
  task automatic t_ce;
    ce <= 1'b0;
    word(1'b1, 1'b0, 7'h10, 2'h0, 3'h0, 1'b0, 21'h0);
    ce <= 1'b1;
    rchk(`OFS_STAT, 32'h0, "frozen word");
    $display("test clock enable done");
  endtask

  task automatic t_roam;
    apb(1'b1, `OFS_CTRL, 32'h0);
    evs(13'h0FFE, 3'h5, 2'h2);
    rchk(`OFS_ROAM_PKT, 32'h6000_0000, "gated");
    chk("attn idle", 32'(attn), 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h27);
    evs(13'h0001, 3'h0, 2'h0);
    evs(13'h029E, 3'h0, 2'h0);
    chk("attn set", 32'(attn), 32'h1);
    rchk(`OFS_ROAM_PKT, 32'h60FC_0000, "flags");
    rchk(`OFS_ROAM_PKT, 32'h6000_0000, "cleared");
    chk("attn clear", 32'(attn), 32'h0);
    evs(13'h02E0, 3'h0, 2'h0);
    rchk(`OFS_ROAM_PKT, 32'h6000_0000, "once per frame");
    evs(13'h0001, 3'h0, 2'h0);
    evs(13'h0460, 3'h5, 2'h0);
    rchk(`OFS_ROAM_PKT, 32'h6003_0000, "net update");
    evs(13'h0500, 3'h6, 2'h0);
    rchk(`OFS_ROAM_PKT, 32'h6001_000E, "collapse");
    evs(13'h0500, 3'h3, 2'h0);
    // The received collapse value stays after its update flag is read.
    rchk(`OFS_ROAM_PKT, 32'h6001_0006, "collapse once");
    chk("attn net bit", 32'(attn), 32'h0);
    evs(13'h0800, 3'h0, 2'h2);
    rchk(`OFS_ROAM_PKT, 32'h6001_0006, "auto noise off");
    evs(13'h1800, 3'h0, 2'h2);
    chk("attn noise", 32'(attn), 32'h1);
    rchk(`OFS_ROAM_PKT, 32'h6001_0206, "host noise");
    apb(1'b1, `OFS_CTRL, 32'h2F);
    evs(13'h0800, 3'h0, 2'h1);
    rchk(`OFS_ROAM_PKT, 32'h6001_0106, "auto noise");
    apb(1'b1, `OFS_CTRL, 32'h3F);
    evs(13'h0800, 3'h0, 2'h3);
    evs(13'h1800, 3'h0, 2'h2);
    rchk(`OFS_ROAM_PKT, 32'h6001_0306, "continuous");
    $display("test roaming done");
  endtask

  ////////////////////////////////////////
  initial begin
    mclk      = 1'b0;
    nrst      = 1'b0;
    ce        = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    wv        = 1'b0;
    wvec      = 1'b0;
    wlong     = 1'b0;
    wchk      = 1'b0;
    wpos      = 7'h00;
    wph       = 2'h0;
    werr      = 3'h0;
    winfo     = 21'h0;
    n_fail    = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_vec;
    t_msg;
    t_ce;
    t_roam;
    close_out;
  end

  // The whole run needs well under a millisecond; this only cuts a hang.
  initial begin
    #3000000;
    n_fail++;
    close_out;
  end
endmodule
